// ### hdl/event_irq.sv
`timescale 1ns/10ps
// sticky event status with write-one-to-clear and mask gating
module event_irq #(
  parameter int N = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [N-1:0] ev,
  input wire logic [N-1:0] clr,
  input wire logic [N-1:0] mask,
  output logic [N-1:0] stat,
  output logic irq
);
  logic [N-1:0] stat_r, stat_nxt;

  // a set in the same cycle as its clear wins
  always_comb begin
    stat_nxt = (stat_r & ~clr) | ev;
  end

  // sticky bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= '0;
    end else if (ce) begin
      stat_r <= stat_nxt;
    end
  end

  assign stat = stat_r;
  assign irq = |(stat_r & mask);
endmodule

// ### hdl/i2c_status_flags.sv
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
// i2c status flags: slave direction, pending flag, arbitration loss
module i2c_status_flags (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // events from the rest of the controller (bus side, synchronised here)
  input wire logic byte_done_pre_ack,
  input wire logic byte_done_post_ack,
  input wire logic rx_mode,
  input wire logic addr_match,
  input wire logic [4:0] match_kind,
  input wire logic rw_bit,
  input wire logic arb_lost_evt,
  input wire logic [3:0] smb_timeout,
  // towards the bus engine
  output logic ack_valid,
  output logic ack_bit,
  output logic fast_ack_enable,
  output logic irq_req,
  output logic irq
);
  import i2c_status_pkg::*;

  // pre, post, rx, match, five kind bits, rw, arb and the two low-side timeout lines
  localparam int NSYNC = 13;

  logic [NSYNC-1:0] raw_in, syn;
  logic s_pre, s_post, s_rx, s_match, s_rw, s_arb;
  logic [4:0] s_kind;
  logic [3:0] s_tmo;
  logic s_pre_d, s_post_d, s_match_d, s_arb_d;
  logic [3:0] s_tmo_d;
  logic pre_rise, post_rise, match_rise, arb_rise, tmo_rise;

  // all event inputs come from the bus-facing engine and are filtered, except smb_timeout[3:2], which are dropped
  assign raw_in = {byte_done_pre_ack, byte_done_post_ack, rx_mode, addr_match,
                   match_kind, rw_bit, arb_lost_evt, smb_timeout[1:0]};

  pin_sync3 #(.W(NSYNC)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(clk_en),
    .d(raw_in),
    .q(syn)
  );

  // the two high-level timeouts sit in bits 3:2 and never raise the flag
  assign s_tmo = {2'b00, syn[1:0]};
  assign {s_pre, s_post, s_rx, s_match, s_kind, s_rw, s_arb} = syn[12:2];

  // edge detect on the filtered events
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_pre_d <= 1'b0;
      s_post_d <= 1'b0;
      s_match_d <= 1'b0;
      s_arb_d <= 1'b0;
      s_tmo_d <= 4'h0;
    end else if (clk_en) begin
      s_pre_d <= s_pre;
      s_post_d <= s_post;
      s_match_d <= s_match;
      s_arb_d <= s_arb;
      s_tmo_d <= s_tmo;
    end
  end

  assign pre_rise = s_pre & ~s_pre_d;
  assign post_rise = s_post & ~s_post_d;
  assign match_rise = s_match & ~s_match_d & (|s_kind);
  assign arb_rise = s_arb & ~s_arb_d;
  assign tmo_rise = |(s_tmo & ~s_tmo_d);

  // ---- register state
  logic [7:0] ctrl_r, ctrl_nxt;
  logic dir_r, dir_nxt;
  logic addrd_r, addrd_nxt;
  logic irqf_r, irqf_nxt;
  logic arbitration_lost_flag_r, arbitration_lost_flag_nxt;
  logic [EV_W-1:0] mask_r, mask_nxt;
  logic ack_valid_r, ack_valid_nxt;
  logic ack_bit_r, ack_bit_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;

  // ahb address phase capture
  logic dp_wr_r, dp_rd_r;
  logic [7:0] dp_addr_r;
  logic take, byte_evt, smb_mode;
  logic wr_status, wr_ctrl, wr_istat, wr_mask;
  logic [EV_W-1:0] ev_vec, ev_stat, ev_clr;

  function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
    hits = (a[7:2] == ofs[7:2]);
  endfunction

  // only whole-word single transfers are taken; other sizes fall through silently
  assign take = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);

  // data phase qualifiers; the address is captured every cycle but only used behind a strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (clk_en) begin
      dp_wr_r <= take & hwrite;
      dp_rd_r <= take & ~hwrite;
      dp_addr_r <= haddr;
    end
  end

  // write strobes live in the data phase, when hwdata stands
  assign wr_status = dp_wr_r & hits(dp_addr_r, STATUS_OFS);
  assign wr_ctrl = dp_wr_r & hits(dp_addr_r, CTRL_OFS);
  assign wr_istat = dp_wr_r & hits(dp_addr_r, IRQ_STAT_OFS);
  assign wr_mask = dp_wr_r & hits(dp_addr_r, IRQ_MASK_OFS);

  assign smb_mode = ctrl_r[CT_SMB_BIT];
  assign fast_ack_enable = ctrl_r[CT_FAST_ACK_ENABLE_BIT];

  // fast ack picks the pre-ack completion, otherwise the post-ack one
  assign byte_evt = fast_ack_enable ? pre_rise : post_rise;

  assign ev_vec = {tmo_rise & smb_mode, arb_rise, match_rise, byte_evt};

  // flag and control next state
  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    dir_nxt = dir_r;
    addrd_nxt = addrd_r;
    irqf_nxt = irqf_r;
    arbitration_lost_flag_nxt = arbitration_lost_flag_r;
    ack_valid_nxt = 1'b0;
    ack_bit_nxt = ack_bit_r;
    if (wr_ctrl) begin
      ctrl_nxt = hwdata[7:0];
      addrd_nxt = 1'b0;
      // a tx ack write during a fast-ack receive releases the held ack slot
      if (hwdata[CT_FAST_ACK_ENABLE_BIT] && s_rx) begin
        ack_valid_nxt = 1'b1;
        ack_bit_nxt = hwdata[CT_TX_ACK_CONTROL_BIT];
      end
    end
    if (wr_mask) begin
      mask_nxt = hwdata[EV_W-1:0];
    end
    // write one to clear; a simultaneous hardware set still wins
    if (wr_status && hwdata[ST_IRQF_BIT]) begin
      irqf_nxt = 1'b0;
    end
    if (wr_status && hwdata[ST_ARBITRATION_LOST_FLAG_BIT]) begin
      arbitration_lost_flag_nxt = 1'b0;
    end
    if (|ev_vec) begin
      irqf_nxt = 1'b1;
    end
    if (arb_rise) begin
      arbitration_lost_flag_nxt = 1'b1;
    end
    if (match_rise) begin
      addrd_nxt = 1'b1;
      dir_nxt = s_rw;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
      dir_r <= STATUS_RST[ST_DIR_BIT];
      addrd_r <= STATUS_RST[ST_ADDRD_BIT];
      irqf_r <= STATUS_RST[ST_IRQF_BIT];
      arbitration_lost_flag_r <= STATUS_RST[ST_ARBITRATION_LOST_FLAG_BIT];
      ack_valid_r <= 1'b0;
      ack_bit_r <= 1'b0;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      dir_r <= dir_nxt;
      addrd_r <= addrd_nxt;
      irqf_r <= irqf_nxt;
      arbitration_lost_flag_r <= arbitration_lost_flag_nxt;
      ack_valid_r <= ack_valid_nxt;
      ack_bit_r <= ack_bit_nxt;
    end
  end

  // per-event sticky status for the mask-gated line
  assign ev_clr = wr_istat ? hwdata[EV_W-1:0] : '0;

  event_irq #(.N(EV_W)) u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(clk_en),
    .ev(ev_vec),
    .clr(ev_clr),
    .mask(mask_r),
    .stat(ev_stat),
    .irq(irq)
  );

  // read mux, registered in the address phase so data stands in the data phase
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (take && !hwrite) begin
      if (hits(haddr, STATUS_OFS)) begin
        hrdata_nxt[ST_ARBITRATION_LOST_FLAG_BIT] = arbitration_lost_flag_r;
        hrdata_nxt[ST_ADDRD_BIT] = addrd_r;
        hrdata_nxt[ST_DIR_BIT] = addrd_r & dir_r;
        hrdata_nxt[ST_IRQF_BIT] = irqf_r;
      end else if (hits(haddr, CTRL_OFS)) begin
        hrdata_nxt[7:0] = ctrl_r;
      end else if (hits(haddr, IRQ_STAT_OFS)) begin
        hrdata_nxt[EV_W-1:0] = ev_stat;
      end else if (hits(haddr, IRQ_MASK_OFS)) begin
        hrdata_nxt[EV_W-1:0] = mask_r;
      end
    end
  end

  // read data stands for the data phase only and drops back to zero after it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      hrdata_r <= hrdata_nxt;
    end
  end

  // zero wait state slave: every transfer finishes in one data phase
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ack_valid = ack_valid_r;
  assign ack_bit = ack_bit_r;
  assign irq_req = irqf_r & ctrl_r[CT_IE_BIT];

  // ---- checks
  a_irq_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_req == (irqf_r && ctrl_r[CT_IE_BIT]))
    else $error("interrupt request does not follow flag and enable");
  a_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && arb_rise |=> irqf_r && arbitration_lost_flag_r)
    else $error("arbitration loss did not set flags");
  a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && wr_status && hwdata[ST_IRQF_BIT] && !(|ev_vec) |=> !irqf_r)
    else $error("pending flag not cleared by write one");
  a_fast_ack_enable_pre: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && fast_ack_enable && pre_rise |=> irqf_r)
    else $error("fast ack byte did not set flag");
  a_nofack_post: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !fast_ack_enable && post_rise |=> irqf_r)
    else $error("byte with ack did not set flag");
  a_dir_rw: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && match_rise |=> addrd_r && (dir_r == $past(s_rw)))
    else $error("direction does not match calling r/w bit");
  a_ack_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && wr_ctrl && hwdata[CT_FAST_ACK_ENABLE_BIT] && s_rx
    |=> ack_valid && ack_bit == $past(hwdata[CT_TX_ACK_CONTROL_BIT]))
    else $error("tx ack choice not driven");
  a_match_set: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && match_rise |=> irqf_r)
    else $error("address match did not set flag");
  a_arbitration_lost_flag_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && arbitration_lost_flag_r && !wr_status |=> arbitration_lost_flag_r)
    else $error("arbitration lost flag dropped without clear");

  // direction value for each r/w bit of the calling address
  a_dir_recv: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && match_rise && !s_rw |=> !dir_r)
    else $error("master write did not give slave receive direction");

  a_dir_xmit: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && match_rise && s_rw |=> dir_r)
    else $error("master read did not give slave transmit direction");

  // low-side timeouts only count in smbus mode
  a_tmo_set: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && smb_mode && tmo_rise |=> irqf_r)
    else $error("smbus timeout did not set flag");

  // the pending flag only drops on a write of one
  a_irqf_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && irqf_r && !(wr_status && hwdata[ST_IRQF_BIT]) |=> irqf_r)
    else $error("pending flag dropped without clear");

  // arbitration flag write-one clear when no new loss arrives
  a_arbitration_lost_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && wr_status && hwdata[ST_ARBITRATION_LOST_FLAG_BIT] && !arb_rise |=> !arbitration_lost_flag_r)
    else $error("arbitration lost flag not cleared by write one");

  // no ack slot is released unless software chose one in receive
  a_ack_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !(wr_ctrl && hwdata[CT_FAST_ACK_ENABLE_BIT] && s_rx) |=> !ack_valid)
    else $error("ack released without a tx ack write");

  // read data is zero outside a read data phase
  a_rd_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !(take && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data outside its data phase");

  // the slave never stalls and never errors
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus response not ready and okay");

  c_match: cover property (@(posedge hclk) disable iff (!hresetn) match_rise && s_rw);
  c_tmo: cover property (@(posedge hclk) disable iff (!hresetn) tmo_rise && smb_mode);
  c_fast_ack_enable: cover property (@(posedge hclk) disable iff (!hresetn) ack_valid && ack_bit);
  c_clear: cover property (@(posedge hclk) disable iff (!hresetn) irqf_r ##1 !irqf_r);
endmodule

// ### hdl/i2c_status_pkg.sv
// constants for the i2c status flag block
package i2c_status_pkg;
  // register byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  // bus_status field positions
  localparam int ST_ARBITRATION_LOST_FLAG_BIT = 4;
  localparam int ST_DIR_BIT = 2;
  localparam int ST_IRQF_BIT = 1;
  localparam int ST_ADDRD_BIT = 3;
  // control field positions
  localparam int CT_FAST_ACK_ENABLE_BIT = 0;
  localparam int CT_TX_ACK_CONTROL_BIT = 1;
  localparam int CT_IE_BIT = 2;
  localparam int CT_SMB_BIT = 3;
  // event status bit positions
  localparam int EV_BYTE = 0;
  localparam int EV_ADDR = 1;
  localparam int EV_ARB = 2;
  localparam int EV_TMO = 3;
  localparam int EV_W = 4;
  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  // ahb codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ### hdl/pin_sync3.sv
`timescale 1ns/10ps
// three-stage synchroniser with agreement filter for bus-side inputs
module pin_sync3 #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r, s2_r, s3_r, q_r;
  logic [W-1:0] q_nxt;

  // a change counts only once stages two and three agree
  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        q_nxt[i] = s3_r[i];
      end
    end
  end

  // stage one feeds stage two only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else if (ce) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

// ### testbench/i2c_bus_model.sv
`timescale 1ns/10ps
// far side of the bus: raises bus events and watches the released ack bit
module i2c_bus_model (
  input wire logic hclk,
  input wire logic go,
  input wire logic [2:0] which,
  input wire logic [4:0] kind,
  input wire logic rw,
  input wire logic [3:0] tmo,
  input wire logic ack_valid,
  input wire logic ack_bit,
  output logic byte_done_pre_ack,
  output logic byte_done_post_ack,
  output logic addr_match,
  output logic [4:0] match_kind,
  output logic rw_bit,
  output logic arb_lost_evt,
  output logic [3:0] smb_timeout,
  output logic busy,
  output int ack_cnt,
  output logic last_ack
);
  logic [4:0] ev_r = 5'h00;
  int hold = 0;
  // hold each event past the input filter, then stay low so the next rise shows
  always @(posedge hclk) begin
    if (go) begin
      ev_r <= 5'h01 << which;
      hold <= 10;
    end else if (hold > 0) begin
      hold <= hold - 1;
      if (hold == 4) ev_r <= 5'h00;
    end
  end
  assign busy = go || hold > 0;
  assign byte_done_pre_ack = ev_r[0];
  assign byte_done_post_ack = ev_r[1];
  assign addr_match = ev_r[2];
  assign arb_lost_evt = ev_r[3];
  assign smb_timeout = ev_r[4] ? tmo : 4'h0;
  // qualifiers are junk outside the match, so a design must latch them
  assign match_kind = ev_r[2] ? kind : ~kind;
  assign rw_bit = ev_r[2] ? rw : ~rw;
  initial ack_cnt = 0;
  // the bus engine sends the ack bit the moment it is released
  always @(posedge hclk) begin
    if (ack_valid === 1'b1) begin
      ack_cnt <= ack_cnt + 1;
      last_ack <= ack_bit;
    end
  end
endmodule

// ### testbench/i2c_status_flags_test.sv
`timescale 1ns/10ps
// self-checking bench for the i2c status flag block
module i2c_status_flags_test;
  import i2c_status_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic rx_mode = 1'b0;
  logic go = 1'b0;
  logic [2:0] which = 3'h0;
  logic [4:0] kind = 5'h00;
  logic rw = 1'b0;
  logic r0;
  logic [3:0] tmo = 4'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, ack_valid, ack_bit, fae, irq_req, irq, busy, last_ack;
  logic bd_pre, bd_post, am, rwb, al;
  logic [4:0] mk;
  logic [3:0] st;
  int ack_cnt;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  // bench model of the registers
  logic [7:0] e_st = 8'h00;
  logic [3:0] e_ctrl = 4'h0;
  logic [3:0] e_ev = 4'h0;
  logic [3:0] e_mask = 4'h0;

  always #20 hclk = ~hclk;

  i2c_status_flags uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .byte_done_pre_ack(bd_pre), .byte_done_post_ack(bd_post), .rx_mode(rx_mode),
    .addr_match(am), .match_kind(mk), .rw_bit(rwb), .arb_lost_evt(al), .smb_timeout(st),
    .ack_valid(ack_valid), .ack_bit(ack_bit), .fast_ack_enable(fae), .irq_req(irq_req),
    .irq(irq));
  i2c_bus_model far (.hclk(hclk), .go(go), .which(which), .kind(kind), .rw(rw), .tmo(tmo),
    .ack_valid(ack_valid), .ack_bit(ack_bit), .byte_done_pre_ack(bd_pre),
    .byte_done_post_ack(bd_post), .addr_match(am), .match_kind(mk), .rw_bit(rwb),
    .arb_lost_evt(al), .smb_timeout(st), .busy(busy), .ack_cnt(ack_cnt), .last_ack(last_ack));

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single word transfer; enters and leaves just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // write and let the bench model follow
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    case (a)
      STATUS_OFS: begin
        e_st[ST_ARBITRATION_LOST_FLAG_BIT] &= ~d[ST_ARBITRATION_LOST_FLAG_BIT];
        e_st[ST_IRQF_BIT] &= ~d[ST_IRQF_BIT];
      end
      CTRL_OFS: begin
        e_ctrl = d[3:0];
        e_st[ST_ADDRD_BIT] = 1'b0;
        e_st[ST_DIR_BIT] = 1'b0;
      end
      IRQ_STAT_OFS: e_ev &= ~d[3:0];
      IRQ_MASK_OFS: e_mask = d[3:0];
      default: ;
    endcase
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic check_all();
    rd_chk(STATUS_OFS, {24'h0, e_st}, "bus_status");
    rd_chk(CTRL_OFS, {28'h0, e_ctrl}, "ctrl");
    rd_chk(IRQ_STAT_OFS, {28'h0, e_ev}, "event status");
    rd_chk(IRQ_MASK_OFS, {28'h0, e_mask}, "mask");
    chk("irq_req", e_st[ST_IRQF_BIT] & e_ctrl[CT_IE_BIT], irq_req);
    chk("irq", |(e_ev & e_mask), irq);
    chk("fast_ack_enable", e_ctrl[CT_FAST_ACK_ENABLE_BIT], fae);
  endtask

  task automatic clr();
    wr(STATUS_OFS, 32'h0000_0012);
    wr(IRQ_STAT_OFS, 32'h0000_000f);
  endtask

  // drive one bus event through the far side, predict, then compare
  task automatic evt(input logic [2:0] w, input logic [4:0] k, input logic r, input logic [3:0] t);
    logic hit;
    which <= w;
    kind <= k;
    rw <= r;
    tmo <= t;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    do @(posedge hclk); while (busy === 1'b1);
    repeat (4) @(posedge hclk);
    case (w)
      3'h0: hit = e_ctrl[CT_FAST_ACK_ENABLE_BIT];
      3'h1: hit = !e_ctrl[CT_FAST_ACK_ENABLE_BIT];
      3'h2: hit = k != 5'h00;
      3'h3: hit = 1'b1;
      default: hit = e_ctrl[CT_SMB_BIT] && t[1:0] != 2'h0;
    endcase
    if (hit) begin
      e_st[ST_IRQF_BIT] = 1'b1;
      e_ev[w == 3'h0 ? 0 : w - 1] = 1'b1;
      if (w == 3'h3) e_st[ST_ARBITRATION_LOST_FLAG_BIT] = 1'b1;
      if (w == 3'h2) e_st[ST_ADDRD_BIT] = 1'b1;
      if (w == 3'h2) e_st[ST_DIR_BIT] = r;
    end
    check_all();
  endtask

  // hang guard: far beyond the few hundred cycles the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'he1aa));
    r0 = 1'($urandom);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_all();
    rd_chk(8'h10, 32'h0, "unmapped");
    // every address kind plus no match, direction alternating from a random start
    for (int i = 0; i < 6; i++) begin
      evt(3'h2, 5'h01 << i, r0 ^ 1'(i), 4'h0);
      clr();
      check_all();
    end
    // byte completion with fast ack off then on
    for (int f = 0; f < 2; f++) begin
      wr(CTRL_OFS, 32'(f));
      evt(3'h0, 5'h00, 1'b0, 4'h0);
      clr();
      evt(3'h1, 5'h00, 1'b0, 4'h0);
      clr();
    end
    evt(3'h3, 5'h00, 1'b0, 4'h0);
    wr(STATUS_OFS, 32'h0000_0010);
    check_all();
    // each timeout line with smbus mode off and on
    for (int s = 0; s < 2; s++) begin
      wr(CTRL_OFS, 32'(s << CT_SMB_BIT));
      for (int t = 1; t < 16; t = t * 2) begin
        evt(3'h4, 5'h00, 1'b0, 4'(t));
        clr();
      end
    end
    // interrupt raised, masked, cleared
    wr(CTRL_OFS, 32'h0000_0004);
    wr(IRQ_MASK_OFS, 32'h0000_0004);
    evt(3'h3, 5'h00, 1'b0, 4'h0);
    wr(IRQ_MASK_OFS, 32'h0);
    check_all();
    clr();
    check_all();
    // ack or nack released in receive mode
    rx_mode <= 1'b1;
    repeat (8) @(posedge hclk);
    for (int b = 0; b < 2; b++) begin
      wr(CTRL_OFS, {30'h0, 1'(b), 1'b1});
      repeat (2) @(posedge hclk);
      chk("ack count", 32'(b + 1), 32'(ack_cnt));
      chk("ack bit", 32'(b), {31'h0, last_ack});
    end
    conclude();
  end
endmodule
